// file: hdl/uart_lms_pkg.sv
// Constants shared by the UART line and modem status block and its helpers.
// Assumes an AXI4-Lite master with 32-bit data and byte addressing.
package uart_lms_pkg;
  // ---------------------------------------------------------------
  // Bus
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [7:0]  OFS_MODEM_CTL = 8'h00;
  localparam logic [7:0]  OFS_LINE_STAT = 8'h04;
  localparam logic [7:0]  OFS_MODEM_ST  = 8'h08;
  localparam logic [7:0]  OFS_SCRATCH   = 8'h0c;
  localparam logic [7:0]  OFS_INT_EN    = 8'h10;
  localparam logic [7:0]  OFS_FEAT_CTL  = 8'h14;
  localparam logic [7:0]  OFS_ENH_FEAT  = 8'h18;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_MODEM_CTL = 8'h00;
  localparam logic [7:0]  RST_SCRATCH   = 8'hff;
  localparam logic [7:0]  RST_ZERO      = 8'h00;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int MCR_DTR       = 0;
  localparam int MCR_RTS       = 1;
  localparam int MCR_OUT1      = 2;
  localparam int MCR_OUT2      = 3;
  localparam int MCR_LOOP      = 4;
  localparam int MCR_XON_ANY   = 5;
  localparam int MCR_IR        = 6;
  localparam int MCR_PRESCALE  = 7;
  localparam int IER_LINE      = 2;
  localparam int IER_MODEM     = 3;
  localparam int FEATURE_CONTROL_REG_SWAP     = 6;
  localparam int EFR_AUTO_CTS  = 7;
  localparam int EFR_SWFC_HI   = 3;
  localparam int EFR_SWFC_LO   = 0;
  localparam int ENHANCED_MODE_SELECT_CNT_HI   = 1;
  localparam int ENHANCED_MODE_SELECT_CNT_LO   = 0;
  // ---------------------------------------------------------------
  // Level counter source
  // ---------------------------------------------------------------
  localparam logic [1:0]  CNT_RX_A      = 2'h0;
  localparam logic [1:0]  CNT_TX        = 2'h1;
  localparam logic [1:0]  CNT_RX_B      = 2'h2;
  localparam logic [1:0]  CNT_ALT       = 2'h3;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam logic [3:0]  FRAME_BITS    = 4'ha;
  localparam logic [1:0]  PRESCALE_LAST = 2'h3;
endpackage

// file: hdl/pin_sync.sv
// Two-stage synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] q
);
  logic [W-1:0] stage1;

  // Stage one feeds stage two only
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      stage1 <= rst_val;
      q      <= rst_val;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end
endmodule // pin_sync
`default_nettype wire

// file: hdl/baud_prescaler.sv
// Reference tick for the baud generator: every clock, or one in four.
// Assumes sel comes from a register on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module baud_prescaler (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic sel,
  output logic      tick
);
  logic [1:0] cnt;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cnt  <= 2'h0;
      tick <= 1'b0;
    end else begin
      cnt  <= cnt + 2'h1;
      tick <= !sel || (cnt == uart_lms_pkg::PRESCALE_LAST);
    end
  end
endmodule // baud_prescaler
`default_nettype wire

// file: hdl/uart_line_modem_status_control.sv
// Per-channel UART line status, modem status and upper modem control logic.
// Assumes the FIFOs, shifters, baud divider and IR codec live outside and
// run on clk_sys; modem pins are asynchronous and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module uart_line_modem_status_control (
  input  wire logic                            clk_sys,
  input  wire logic                            nrst,
  // AXI4-Lite slave
  input  wire logic [uart_lms_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [31:0]                     s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [uart_lms_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [31:0]                          s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  // Modem and serial pins
  input  wire logic                            rx_pin,
  input  wire logic                            cts_n,
  input  wire logic                            dsr_n,
  input  wire logic                            ring_indicator_n,
  input  wire logic                            carrier_detect_n,
  output logic                                 tx_pin,
  // Receive datapath
  input  wire logic                            rx_bit_tick,
  input  wire logic                            rx_char_done,
  input  wire logic                            rx_char_is_flow,
  input  wire logic                            rx_fifo_full,
  input  wire logic                            rx_fifo_empty,
  input  wire logic [7:0]                      rx_fifo_count,
  input  wire logic                            rx_head_parity_err,
  input  wire logic                            rx_head_framing_err,
  input  wire logic                            rx_head_break,
  input  wire logic                            rx_fifo_err_any,
  input  wire logic                            ir_rx_decoded,
  output logic                                 rx_line,
  output logic                                 rx_fifo_push,
  output logic                                 rx_push_break,
  // Transmit datapath
  input  wire logic                            tx_serial_raw,
  input  wire logic                            ir_tx_encoded,
  input  wire logic                            tx_fifo_empty,
  input  wire logic                            tx_shift_empty,
  input  wire logic                            tx_char_done,
  input  wire logic [7:0]                      tx_fifo_count,
  output logic                                 tx_resume_sw,
  output logic                                 tx_allowed,
  output logic                                 ir_enable,
  output logic                                 baud_ref_tick,
  output logic [3:0]                           modem_ctrl_low,
  // Interrupt requests
  output logic                                 line_status_irq,
  output logic                                 modem_status_irq
);
  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  logic [7:0] modem_line_control;
  logic [7:0] scratch_store;
  logic [7:0] enhanced_mode_select;
  logic [7:0] interrupt_enable_reg;
  logic [7:0] feature_control_reg;
  logic [7:0] enhanced_feature_reg;
  logic       overrun;
  logic [3:0] delta;
  logic [3:0] prev_level;
  logic       alt_tx_next;
  logic       brk_active;
  logic [3:0] brk_cnt;
  logic       break_push;

  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [7:0] w_byte;
  logic       w_lane0;
  logic       do_write;
  logic       do_read;

  logic [3:0] pins_s;
  logic       rx_s;
  logic [3:0] msr_level;
  logic [7:0] line_status;
  logic [7:0] modem_input_status;
  logic [7:0] fifo_level_readback;
  logic       sw_flow_active;
  logic       swap;
  logic       loop_en;
  logic       rx_src;
  logic       rd_line;
  logic       rd_modem;
  logic       rd_level;
  logic [7:0] rd_byte;
  logic       rd_hit;

  assign swap    = feature_control_reg[uart_lms_pkg::FEATURE_CONTROL_REG_SWAP];
  assign loop_en = modem_line_control[uart_lms_pkg::MCR_LOOP];

  // ---------------------------------------------------------------
  // Pin synchronisers and baud prescaler
  // ---------------------------------------------------------------
  pin_sync #(.W(5)) u_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .d       ({rx_pin, carrier_detect_n, ring_indicator_n, dsr_n, cts_n}),
    .rst_val (5'h1f),
    .q       ({rx_s, pins_s})
  );

  baud_prescaler u_presc (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .sel     (modem_line_control[uart_lms_pkg::MCR_PRESCALE]),
    .tick    (baud_ref_tick)
  );

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  // Address and data are taken in either order and held until both are in
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= uart_lms_pkg::RST_ZERO;
      w_byte       <= uart_lms_pkg::RST_ZERO;
      w_lane0      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= uart_lms_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known(aw_addr) ? uart_lms_pkg::RESP_OKAY : uart_lms_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic wr_known(input logic [7:0] a);
    wr_known = (a == uart_lms_pkg::OFS_MODEM_CTL) || (a == uart_lms_pkg::OFS_SCRATCH) ||
               (a == uart_lms_pkg::OFS_INT_EN) || (a == uart_lms_pkg::OFS_FEAT_CTL) ||
               (a == uart_lms_pkg::OFS_ENH_FEAT);
  endfunction

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      modem_line_control   <= uart_lms_pkg::RST_MODEM_CTL;
      scratch_store        <= uart_lms_pkg::RST_SCRATCH;
      enhanced_mode_select <= uart_lms_pkg::RST_ZERO;
      interrupt_enable_reg <= uart_lms_pkg::RST_ZERO;
      feature_control_reg  <= uart_lms_pkg::RST_ZERO;
      enhanced_feature_reg <= uart_lms_pkg::RST_ZERO;
    end else if (do_write && w_lane0) begin
      case (aw_addr)
        uart_lms_pkg::OFS_MODEM_CTL: modem_line_control <= w_byte;
        uart_lms_pkg::OFS_SCRATCH: begin
          if (swap) begin
            enhanced_mode_select <= w_byte;
          end else begin
            scratch_store <= w_byte;
          end
        end
        uart_lms_pkg::OFS_INT_EN:   interrupt_enable_reg <= w_byte;
        uart_lms_pkg::OFS_FEAT_CTL: feature_control_reg  <= w_byte;
        uart_lms_pkg::OFS_ENH_FEAT: enhanced_feature_reg <= w_byte;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign do_read       = s_axi_arvalid && s_axi_arready;
  assign rd_line       = do_read && (s_axi_araddr == uart_lms_pkg::OFS_LINE_STAT);
  assign rd_modem      = do_read && (s_axi_araddr == uart_lms_pkg::OFS_MODEM_ST);
  assign rd_level      = do_read && (s_axi_araddr == uart_lms_pkg::OFS_SCRATCH) && swap;

  always_comb begin
    rd_byte = uart_lms_pkg::RST_ZERO;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      uart_lms_pkg::OFS_MODEM_CTL: rd_byte = modem_line_control;
      uart_lms_pkg::OFS_LINE_STAT: rd_byte = line_status;
      uart_lms_pkg::OFS_MODEM_ST:  rd_byte = modem_input_status;
      uart_lms_pkg::OFS_SCRATCH:   rd_byte = swap ? fifo_level_readback : scratch_store;
      uart_lms_pkg::OFS_INT_EN:    rd_byte = interrupt_enable_reg;
      uart_lms_pkg::OFS_FEAT_CTL:  rd_byte = feature_control_reg;
      uart_lms_pkg::OFS_ENH_FEAT:  rd_byte = enhanced_feature_reg;
      default:                     rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= uart_lms_pkg::RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h0, rd_byte};
      s_axi_rresp  <= rd_hit ? uart_lms_pkg::RESP_OKAY : uart_lms_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // FIFO level counter
  // ---------------------------------------------------------------
  always_comb begin
    case (enhanced_mode_select[uart_lms_pkg::ENHANCED_MODE_SELECT_CNT_HI:uart_lms_pkg::ENHANCED_MODE_SELECT_CNT_LO])
      uart_lms_pkg::CNT_TX:  fifo_level_readback = tx_fifo_count;
      uart_lms_pkg::CNT_ALT: fifo_level_readback = alt_tx_next ? tx_fifo_count : rx_fifo_count;
      default:               fifo_level_readback = rx_fifo_count;
    endcase
  end

  // Any write of the selection restarts the sequence at the receive count
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      alt_tx_next <= 1'b0;
    end else if (do_write && w_lane0 && swap && (aw_addr == uart_lms_pkg::OFS_SCRATCH)) begin
      alt_tx_next <= 1'b0;
    end else if (rd_level &&
                 (enhanced_mode_select[uart_lms_pkg::ENHANCED_MODE_SELECT_CNT_HI:uart_lms_pkg::ENHANCED_MODE_SELECT_CNT_LO] ==
                  uart_lms_pkg::CNT_ALT)) begin
      alt_tx_next <= !alt_tx_next;
    end
  end

  // ---------------------------------------------------------------
  // Serial path routing
  // ---------------------------------------------------------------
  assign ir_enable = modem_line_control[uart_lms_pkg::MCR_IR];
  // Loopback feeds the transmit side back, IR-encoded when IR is on; in loopback the pin is held high, or low with IR on
  assign rx_src = loop_en ? (ir_enable ? ir_tx_encoded : tx_serial_raw) :
                  (ir_enable ? ir_rx_decoded : rx_s);

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rx_line <= 1'b1;
      tx_pin  <= 1'b1;
    end else begin
      rx_line <= rx_src;
      if (loop_en) begin
        tx_pin <= !ir_enable;
      end else begin
        tx_pin <= ir_enable ? ir_tx_encoded : tx_serial_raw;
      end
    end
  end

  // ---------------------------------------------------------------
  // Receive status
  // ---------------------------------------------------------------
  assign sw_flow_active = |enhanced_feature_reg[uart_lms_pkg::EFR_SWFC_HI:uart_lms_pkg::EFR_SWFC_LO];
  // A completed character with the FIFO full is dropped; FIFO untouched
  assign rx_fifo_push  = !rx_fifo_full &&
                         ((rx_char_done && !(sw_flow_active && rx_char_is_flow)) || break_push);
  assign rx_push_break = break_push && !rx_fifo_full;
  assign tx_resume_sw  = rx_char_done && modem_line_control[uart_lms_pkg::MCR_XON_ANY];

  // Overrun sticks until line status is read; a new event wins the clear
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      overrun <= 1'b0;
    end else if (rx_char_done && rx_fifo_full) begin
      overrun <= 1'b1;
    end else if (rd_line) begin
      overrun <= 1'b0;
    end
  end

  // Break: count bit ticks while the line stays low; one push per break
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      brk_cnt    <= 4'h0;
      brk_active <= 1'b0;
      break_push <= 1'b0;
    end else begin
      break_push <= 1'b0;
      if (rx_line) begin
        brk_cnt    <= 4'h0;
        brk_active <= 1'b0;
      end else if (rx_bit_tick && !brk_active) begin
        if (brk_cnt == uart_lms_pkg::FRAME_BITS - 4'h1) begin
          brk_active <= 1'b1;
          break_push <= 1'b1;
        end else begin
          brk_cnt <= brk_cnt + 4'h1;
        end
      end
    end
  end

  assign line_status = {
    rx_fifo_err_any,
    tx_fifo_empty && tx_shift_empty,
    tx_fifo_empty,
    rx_head_break || brk_active,
    rx_head_framing_err,
    rx_head_parity_err,
    overrun,
    !rx_fifo_empty
  };

  assign line_status_irq = interrupt_enable_reg[uart_lms_pkg::IER_LINE] &&
                           (overrun || rx_head_parity_err || rx_head_framing_err ||
                            rx_head_break || brk_active);

  // ---------------------------------------------------------------
  // Modem status
  // ---------------------------------------------------------------
  // Order: cts, dsr, ring, carrier
  assign msr_level = loop_en ?
    {modem_line_control[uart_lms_pkg::MCR_OUT2], modem_line_control[uart_lms_pkg::MCR_OUT1],
     modem_line_control[uart_lms_pkg::MCR_DTR], modem_line_control[uart_lms_pkg::MCR_RTS]} :
    ~pins_s;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      prev_level <= 4'h0;
      delta      <= 4'h0;
    end else begin
      prev_level <= msr_level;
      for (int i = 0; i < 4; i++) begin
        // Ring reports only its trailing edge: status 1 to 0 is pin 0 to 1
        if ((i == 2) ? (prev_level[i] && !msr_level[i]) : (prev_level[i] != msr_level[i])) begin
          delta[i] <= 1'b1;
        end else if (rd_modem) begin
          delta[i] <= 1'b0;
        end
      end
    end
  end

  assign modem_input_status = {msr_level, delta};
  assign modem_status_irq   = interrupt_enable_reg[uart_lms_pkg::IER_MODEM] && (|delta);
  assign modem_ctrl_low     = modem_line_control[uart_lms_pkg::MCR_OUT2:uart_lms_pkg::MCR_DTR];

  // ---------------------------------------------------------------
  // Auto CTS gating
  // ---------------------------------------------------------------
  // Decision only changes between characters so a frame is never cut short
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tx_allowed <= 1'b1;
    end else if (tx_shift_empty || tx_char_done) begin
      tx_allowed <= !(enhanced_feature_reg[uart_lms_pkg::EFR_AUTO_CTS] && !msr_level[0]);
    end
  end
endmodule // uart_line_modem_status_control
`default_nettype wire

// file: test/modem_peer.sv
// Modem and remote line partner: drives modem pins and serial input.
// Assumes want is set by the bench; all pins change right after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module modem_peer (
  input  wire logic       clk_sys,
  input  wire logic [4:0] want,
  output logic            cts_n,
  output logic            dsr_n,
  output logic            ring_indicator_n,
  output logic            carrier_detect_n,
  output logic            rx_pin
);
  // Levels move only after an edge, as an unrelated modem would not
  always @(posedge clk_sys) begin
    {rx_pin, carrier_detect_n, ring_indicator_n, dsr_n, cts_n} <= want;
  end
endmodule // modem_peer
`default_nettype wire

// file: test/uart_lms_checker.sv
// Concurrent checks on the line and modem status block.
// Assumes a bind into the top module; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module uart_lms_checker (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_char_done,
  input wire logic rx_char_is_flow,
  input wire logic rx_fifo_full,
  input wire logic rx_fifo_push,
  input wire logic rx_push_break,
  input wire logic tx_resume_sw,
  input wire logic baud_ref_tick,
  input wire logic tx_allowed,
  input wire logic tx_shift_empty,
  input wire logic tx_char_done
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_resume_cause: assert property (tx_resume_sw |-> rx_char_done) else $error("resume without char");
  a_store_char: assert property (rx_char_done && !rx_fifo_full && !rx_char_is_flow |-> rx_fifo_push)
    else $error("char not stored");
  a_overrun_drop: assert property (rx_char_done && rx_fifo_full |-> !rx_fifo_push)
    else $error("push into full fifo");
  a_break_once: assert property (rx_push_break |-> rx_fifo_push ##1 !rx_push_break)
    else $error("break push wrong");
  a_tick_gap: assert property (!baud_ref_tick |-> ##[1:3] baud_ref_tick) else $error("tick gap");
  a_cts_boundary: assert property ($changed(tx_allowed) |-> $past(tx_shift_empty || tx_char_done))
    else $error("halt mid char");
  a_bvalid_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rvalid_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  c_resume: cover property (tx_resume_sw);
  c_break: cover property (rx_push_break);
  c_halt: cover property (!tx_allowed);
endmodule // uart_lms_checker
bind uart_line_modem_status_control uart_lms_checker chk (.*);
`default_nettype wire

// file: test/tb.sv
// Register level bench for the line and modem status block.
// Assumes modem_peer on the pins and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys = 1'h0, nrst = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, rx_bit_tick = 1'h0, rx_char_done = 1'h0, rx_fifo_full = 1'h0;
  logic rx_char_is_flow = 1'h0, rx_fifo_empty = 1'h1, rx_head_parity_err = 1'h0, rx_head_framing_err = 1'h0;
  logic rx_head_break = 1'h0, rx_fifo_err_any = 1'h0, ir_rx_decoded = 1'h0, tx_serial_raw = 1'h1;
  logic ir_tx_encoded = 1'h0, tx_fifo_empty = 1'h1, tx_shift_empty = 1'h1, tx_char_done = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rx_fifo_count = 8'h11, tx_fifo_count = 8'h22;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf, modem_ctrl_low;
  logic [4:0]  want = 5'h1f;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_pin, rx_line, rx_fifo_push;
  logic rx_push_break, tx_resume_sw, tx_allowed, ir_enable, baud_ref_tick, line_status_irq, modem_status_irq;
  logic cts_n, dsr_n, ring_indicator_n, carrier_detect_n, rx_pin;
  int mismatches = 0, total_checks = 0, cyc = 0, nb = 0, n;
  uart_line_modem_status_control uut (.*);
  modem_peer peer (.*);
  initial forever #25 clk_sys = ~clk_sys;
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = uart_lms_pkg::RESP_OKAY);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) s_axi_bready <= 1'h0;
      if (s_axi_bvalid) chk(s_axi_bresp, er);
    end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er = uart_lms_pkg::RESP_OKAY);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk({s_axi_rresp, s_axi_rdata}, {er, 24'h0, e});
  endtask
  // Hang guard well above the few hundred cycles the sequence needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (rx_push_break === 1'h1) nb <= nb + 1;
    if (cyc == 20000) begin
      mismatches++;
      conclude();
    end
  end
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'h1;
    @(posedge clk_sys);
    rd(8'h0c, 8'hff);
    rd(8'h00, 8'h00);
    rd(8'h08, 8'h00);
    rd(8'h1c, 8'h00, uart_lms_pkg::RESP_SLVERR);
    wr(8'h04, 8'h00, uart_lms_pkg::RESP_SLVERR);
    wr(8'h0c, 8'h5a);
    rd(8'h0c, 8'h5a);
    want <= 5'h1e;
    repeat (5) @(posedge clk_sys);
    rd(8'h08, 8'h11);
    rd(8'h08, 8'h10);
    want <= 5'h1a;
    repeat (5) @(posedge clk_sys);
    rd(8'h08, 8'h50);
    want <= 5'h1e;
    repeat (5) @(posedge clk_sys);
    rd(8'h08, 8'h14);
    wr(8'h00, 8'h1f);
    repeat (5) @(posedge clk_sys);
    rd(8'h08, 8'hfa);
    chk({modem_ctrl_low, tx_pin}, 5'h1f);
    wr(8'h00, 8'h40);
    repeat (3) @(posedge clk_sys);
    chk({ir_enable, tx_pin}, 2'h2);
    for (int i = 0; i < 2; i++) begin
      wr(8'h00, {i[0], 7'h20});
      n = 0;
      repeat (40) begin
        @(posedge clk_sys);
        n += baud_ref_tick;
      end
      chk(n, i ? 10 : 40);
    end
    rx_char_done <= 1'h1;
    rx_char_is_flow <= 1'h1;
    @(negedge clk_sys) chk({tx_resume_sw, rx_fifo_push}, 2'h3);
    @(posedge clk_sys) rx_fifo_full <= 1'h1;
    rx_char_is_flow <= 1'h0;
    @(negedge clk_sys) chk(rx_fifo_push, 1'h0);
    @(posedge clk_sys) rx_fifo_full <= 1'h0;
    @(negedge clk_sys) chk(rx_fifo_push, 1'h1);
    @(posedge clk_sys) rx_char_done <= 1'h0;
    rd(8'h04, 8'h62);
    rd(8'h04, 8'h60);
    {rx_fifo_empty, tx_fifo_empty} <= 2'h0;
    {rx_head_parity_err, rx_head_framing_err, rx_fifo_err_any} <= 3'h7;
    rd(8'h04, 8'h8d);
    wr(8'h10, 8'h0c);
    chk({line_status_irq, modem_status_irq}, 2'h3);
    want <= 5'h0e;
    repeat (26) @(posedge clk_sys) rx_bit_tick <= ~rx_bit_tick;
    chk(nb, 1);
    chk(rx_line, 1'h0);
    rd(8'h04, 8'h9d);
    want <= 5'h1e;
    repeat (5) @(posedge clk_sys);
    rd(8'h04, 8'h8d);
    wr(8'h14, 8'h40);
    for (int i = 0; i < 4; i++) begin
      wr(8'h0c, i[7:0]);
      rd(8'h0c, i == 1 ? 8'h22 : 8'h11);
    end
    rd(8'h0c, 8'h22);
    rd(8'h0c, 8'h11);
    wr(8'h14, 8'h00);
    rd(8'h0c, 8'h5a);
    wr(8'h18, 8'h81);
    rx_char_done <= 1'h1;
    rx_char_is_flow <= 1'h1;
    @(negedge clk_sys) chk({tx_resume_sw, rx_fifo_push}, 2'h2);
    @(posedge clk_sys) rx_char_done <= 1'h0;
    tx_shift_empty <= 1'h0;
    want <= 5'h1f;
    repeat (6) @(posedge clk_sys);
    chk(tx_allowed, 1'h1);
    tx_char_done <= 1'h1;
    @(posedge clk_sys) tx_char_done <= 1'h0;
    repeat (2) @(posedge clk_sys);
    chk(tx_allowed, 1'h0);
    want <= 5'h1e;
    tx_shift_empty <= 1'h1;
    repeat (6) @(posedge clk_sys);
    chk(tx_allowed, 1'h1);
    conclude();
  end
endmodule // tb
`default_nettype wire
